// >>> urse_pkg.sv
// Purpose: Shared constants and types for the RXCMD status encoder
// Assumes: 20 MHz system clock, classic Wishbone register access
// Notes: Offsets are byte addresses of 32-bit registers
package urse_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_LAST_RXCMD = 8'h0C;
    // Control register field positions
    localparam int CTL_XCVR_LO = 0;
    localparam int CTL_TERM = 2;
    localparam int CTL_OPMODE_LO = 3;
    localparam int CTL_DP_PD = 5;
    localparam int CTL_DM_PD = 6;
    localparam int CTL_USE_EXT = 7;
    localparam int CTL_INVERT = 8;
    localparam int CTL_PASSTHRU = 9;
    // Interrupt enable field positions
    localparam int IEN_VBUS_RISE_LO = 0;
    localparam int IEN_VBUS_FALL_LO = 3;
    localparam int IEN_HDIS_RISE = 6;
    localparam int IEN_HDIS_FALL = 7;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0009;
    localparam logic [31:0] IRQ_EN_RESET = 32'h0000_0000;
    localparam logic [1:0] XCVR_HS = 2'h0;
    localparam logic [1:0] XCVR_LS = 2'h2;
    localparam logic [1:0] OPMODE_CHIRP = 2'h2;
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J = 2'h1;
    localparam logic [1:0] LS_K = 2'h2;
    localparam logic [1:0] LS_SE1 = 2'h3;
    localparam logic [1:0] EV_IDLE = 2'h0;
    localparam logic [1:0] EV_ACTIVE = 2'h1;
    localparam logic [1:0] EV_ERROR = 2'h3;
    localparam logic [1:0] EV_DISCON = 2'h2;

    typedef struct packed {
        logic alt_int;
        logic id;
        logic [1:0] rx_event;
        logic [1:0] vbus_state;
        logic [1:0] line_state;
    } urse_rxcmd_t;

    typedef struct packed {
        logic dp;
        logic dm;
        logic squelch;
        logic hs_diff;
        logic session_end_flag;
        logic session_valid_flag;
        logic vbus_valid_flag;
        logic fault;
        logic id;
        logic rx_active;
        logic rx_error;
        logic host_disconnect;
    } urse_pins_t;
endpackage

// >>> urse_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk_i
// Notes: Output changes only when stages two and three agree
module urse_sync #(
    parameter int WIDTH = 12
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gen_bit
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    sync_o[g] <= 1'b0;
                end else if (stage2[g] == stage3[g]) begin
                    sync_o[g] <= stage3[g];
                end
            end
        end
    endgenerate
endmodule

// >>> urse_encoder.sv
// Purpose: Encode line, VBUS and receive status into RXCMD bytes
// Assumes: Pins asynchronous; registers over classic Wishbone
// Notes: One RXCMD is driven with dir for one cycle per unmasked change
// Contract
// - Any DP/DM line change outside the HS transceiver setting sends an RXCMD with new line state.
// - Peripheral full-speed: 00 SE0, 01 J, 10 K, 11 SE1.
// - Peripheral high-speed: squelch 00, else 01; chirp splits by HS receiver.
// - Host low-speed: 01 K, 10 J; host full-speed uses J=01, K=10.
// - Host high-speed squelch encoding; chirp opmode splits by HS receiver.
// - VBUS state: 00 below end, 01, 10 session valid, 11 VBUS valid.
// - Session end and valid come straight from comparators.
// - VBUS state change sends RXCMD when matching edge enable set.
// - Passthrough, with external use also set, puts fault (after invert) into VBUS valid indication.
// - Receive event: 00 idle, 01 active, 11 error, 10 disconnect.
// - SYNC shows receive active by dir+nxt or RXCMD.
// - Receive active stays indicated through whole packet.
// - Receive error drops nxt and sends error RXCMD.
// - Host disconnect valid only as host with both pulldowns.
// - Disconnect edge enables gate RXCMD on each disconnect change.
// - RXCMD byte on data with dir: line, vbus, event, id, alt.
// - External fault change sends RXCMD through VBUS valid indication.
module urse_encoder (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic line_clk_i,
    input wire urse_pkg::urse_pins_t pins_i,
    output logic dir_o,
    output logic nxt_o,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic line_clk_seen_o
);
    urse_pkg::urse_pins_t pins;
    logic line_clk_s;
    logic line_clk_d;
    logic [31:0] control;
    logic [31:0] irq_en;
    logic [31:0] rxcmd_count;
    urse_pkg::urse_rxcmd_t current;
    urse_pkg::urse_rxcmd_t reported;
    urse_pkg::urse_rxcmd_t next_reported;
    logic send;
    logic fault_level;
    logic vbus_valid_ind;
    logic host_mode;
    logic wb_hit;

    urse_sync #(
        .WIDTH(13)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({line_clk_i, pins_i}),
        .sync_o({line_clk_s, pins})
    );

    // Field decode used by the line state encoder
    function automatic logic [1:0] field2(input logic [31:0] r, input int lo);
        field2 = r[lo +: 2];
    endfunction

    // Line state, combining role and mode
    function automatic logic [1:0] line_code(input logic [31:0] c, input logic hm,
                                             input urse_pkg::urse_pins_t p);
        logic [1:0] xcvr;
        logic [1:0] fs;
        xcvr = field2(c, urse_pkg::CTL_XCVR_LO);
        fs = {p.dm, p.dp} == 2'h0 ? urse_pkg::LS_SE0 :
             {p.dm, p.dp} == 2'h3 ? urse_pkg::LS_SE1 :
             p.dp ? urse_pkg::LS_J : urse_pkg::LS_K;
        if (xcvr == urse_pkg::XCVR_HS) begin
            if (p.squelch) begin
                line_code = 2'h0;
            end else if ((hm && field2(c, urse_pkg::CTL_OPMODE_LO) == urse_pkg::OPMODE_CHIRP) ||
                         (!hm && c[urse_pkg::CTL_TERM])) begin
                line_code = p.hs_diff ? 2'h1 : 2'h2;
            end else begin
                line_code = 2'h1;
            end
        end else if (hm && xcvr == urse_pkg::XCVR_LS) begin
            // Low-speed K drives DP high, so 01 is K
            line_code = {p.dm, p.dp};
        end else begin
            line_code = fs;
        end
    endfunction

    assign host_mode = control[urse_pkg::CTL_DP_PD] & control[urse_pkg::CTL_DM_PD];
    assign fault_level = pins.fault ^ control[urse_pkg::CTL_INVERT];
    assign vbus_valid_ind = !control[urse_pkg::CTL_USE_EXT] ? pins.vbus_valid_flag :
                            control[urse_pkg::CTL_PASSTHRU] ? fault_level :
                            (fault_level & pins.vbus_valid_flag);

    always_comb begin
        current.alt_int = 1'b0;
        current.id = pins.id;
        current.line_state = line_code(control, host_mode, pins);
        if (vbus_valid_ind) begin
            current.vbus_state = 2'h3;
        end else if (pins.session_valid_flag) begin
            current.vbus_state = 2'h2;
        end else if (pins.session_end_flag) begin
            current.vbus_state = 2'h0;
        end else begin
            current.vbus_state = 2'h1;
        end
        if (host_mode && pins.host_disconnect) begin
            current.rx_event = urse_pkg::EV_DISCON;
        end else if (pins.rx_active && pins.rx_error) begin
            current.rx_event = urse_pkg::EV_ERROR;
        end else if (pins.rx_active) begin
            current.rx_event = urse_pkg::EV_ACTIVE;
        end else begin
            current.rx_event = urse_pkg::EV_IDLE;
        end
    end

    // Gating: masked VBUS or disconnect edges are absorbed silently
    always_comb begin
        logic [1:0] vr;
        logic [1:0] vf;
        logic up;
        logic dis_now;
        logic dis_was;
        vr = irq_en[urse_pkg::IEN_VBUS_RISE_LO +: 2];
        vf = irq_en[urse_pkg::IEN_VBUS_FALL_LO +: 2];
        up = current.vbus_state > reported.vbus_state;
        dis_now = current.rx_event == urse_pkg::EV_DISCON;
        dis_was = reported.rx_event == urse_pkg::EV_DISCON;
        next_reported = current;
        send = current != reported;
        // VBUS change needs its edge enable
        if (current.vbus_state != reported.vbus_state) begin
            if (!(up ? vr[current.vbus_state[1]] : vf[reported.vbus_state[1]])) begin
                send = (current.line_state != reported.line_state) || (current.id != reported.id) ||
                       (current.rx_event != reported.rx_event);
            end
        end
        // Disconnect change needs its edge enable
        if (dis_now != dis_was && !(dis_now ? irq_en[urse_pkg::IEN_HDIS_RISE]
                                              : irq_en[urse_pkg::IEN_HDIS_FALL])) begin
            send = (current.line_state != reported.line_state) || (current.id != reported.id) ||
                   (current.vbus_state != reported.vbus_state && send);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reported <= '0;
            dir_o <= 1'b0;
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
            rxcmd_count <= 32'h0000_0000;
        end else begin
            reported <= next_reported;
            dir_o <= send || pins.rx_active;
            data_o <= send ? next_reported : 8'h00;
            data_oe_o <= send || pins.rx_active;
            if (send) begin
                rxcmd_count <= rxcmd_count + 32'h0000_0001;
            end
        end
    end

    // nxt with dir while active, dropped on error
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            nxt_o <= 1'b0;
        end else begin
            nxt_o <= pins.rx_active && !pins.rx_error && !send;
        end
    end

    // Link clock edge seen flag
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            line_clk_d <= 1'b0;
            line_clk_seen_o <= 1'b0;
        end else begin
            line_clk_d <= line_clk_s;
            line_clk_seen_o <= line_clk_s & ~line_clk_d;
        end
    end

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            control <= urse_pkg::CONTROL_RESET;
            irq_en <= urse_pkg::IRQ_EN_RESET;
        end else if (wb_hit && wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b] && wb_adr_i == urse_pkg::ADDR_CONTROL) begin
                    control[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
                if (wb_sel_i[b] && wb_adr_i == urse_pkg::ADDR_IRQ_EN) begin
                    irq_en[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            unique case (wb_adr_i)
                urse_pkg::ADDR_CONTROL: wb_dat_o <= {22'h0, control[9:0]};
                urse_pkg::ADDR_IRQ_EN: wb_dat_o <= {24'h0, irq_en[7:0]};
                urse_pkg::ADDR_STATUS: wb_dat_o <= {24'h0, current};
                urse_pkg::ADDR_LAST_RXCMD: wb_dat_o <= rxcmd_count;
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// >>> urse_monitor.sv
// Purpose: Port checks for the RXCMD status encoder
// Assumes: One clock domain, synchronous active-high reset
// Notes: Pins are async, so pin-based checks wait out the synchroniser
module urse_monitor (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire urse_pkg::urse_pins_t pins_i,
    input wire logic dir_o,
    input wire logic nxt_o,
    input wire logic [7:0] data_o,
    input wire logic data_oe_o,
    input wire logic line_clk_seen_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus answer late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer too long");
    oe_follow_a: assert property (data_oe_o == dir_o)
        else $error("data enable differs from dir");
    idle_bus_a: assert property (!dir_o |-> data_o == 8'h00)
        else $error("data bus not idle");
    nxt_dir_a: assert property (nxt_o |-> dir_o)
        else $error("nxt without dir");
    rx_frame_a: assert property (pins_i.rx_active [*6] |-> dir_o)
        else $error("receive frame lost dir");
    rx_quiet_a: assert property ((!pins_i.rx_active) [*6] |-> !nxt_o)
        else $error("nxt while idle");
    err_nxt_a: assert property ((pins_i.rx_active && pins_i.rx_error) [*6] |-> !nxt_o)
        else $error("nxt during receive error");
    alt_zero_a: assert property (dir_o && !nxt_o |-> !data_o[7])
        else $error("alternate bit set");
    id_bit_a: assert property ($stable(pins_i.id) [*6] ##0 ($rose(dir_o) && !nxt_o) |-> data_o[6] == pins_i.id)
        else $error("id bit wrong");
    clk_seen_a: assert property (line_clk_seen_o |=> !line_clk_seen_o)
        else $error("link clock pulse too long");
    cover property ($rose(dir_o));
    cover property (nxt_o);
    cover property (wb_ack_o);
endmodule

// >>> urse_link_model.sv
// Purpose: Link-side receiver of status bytes
// Assumes: dir with nxt low carries a status byte
// Notes: Zero bytes repeated during a failed packet are not new commands
module urse_link_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic dir_i,
    input wire logic nxt_i,
    input wire logic [7:0] data_i,
    output logic [7:0] last_cmd_o,
    output logic [15:0] cmd_count_o,
    output logic rx_busy_o,
    output logic drop_o
);
    logic dir_q;
    logic is_cmd;
    assign is_cmd = dir_i && !nxt_i && (!dir_q || data_i != 8'h00);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dir_q <= 1'b0;
            last_cmd_o <= 8'h00;
            cmd_count_o <= 16'h0000;
        end else begin
            dir_q <= dir_i;
            if (is_cmd) begin
                last_cmd_o <= data_i;
                cmd_count_o <= cmd_count_o + 16'h0001;
            end
        end
    end
    // active by either method, ends at first sign
    always_ff @(posedge clk_i) begin
        if (reset_i || !dir_i) rx_busy_o <= 1'b0;
        else if (nxt_i) rx_busy_o <= 1'b1;
        else if (is_cmd) rx_busy_o <= data_i[4];
    end
    // erroneous packet dropped until next start
    always_ff @(posedge clk_i) begin
        if (reset_i) drop_o <= 1'b0;
        else if (is_cmd && data_i[5:4] == 2'h3) drop_o <= 1'b1;
        else if (dir_i && nxt_i && !rx_busy_o) drop_o <= 1'b0;
    end
endmodule

// >>> tb.sv
// Purpose: Self-checking bench for the RXCMD status encoder
// Assumes: 20 MHz clock, 400 ns link clock
// Notes: Every pin step must change the byte, else it times out
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic line_clk_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'hF;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, dir_o, nxt_o, data_oe_o, line_clk_seen_o, rx_busy, drop;
    logic [7:0] data_o, last_cmd;
    logic [15:0] n_cmd;
    urse_pkg::urse_pins_t pins_i = 12'h080;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_seen = 0;
    always #25 clk_i = ~clk_i;
    always #200 line_clk_i = ~line_clk_i;
    always @(posedge clk_i) if (line_clk_seen_o === 1'b1) n_seen <= n_seen + 1;
    urse_encoder u_dut (.clk_i, .reset_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
        .wb_dat_o, .wb_ack_o, .line_clk_i, .pins_i, .dir_o, .nxt_o, .data_o, .data_oe_o, .line_clk_seen_o);
    urse_link_model u_link (.clk_i, .reset_i, .dir_i(dir_o), .nxt_i(nxt_o), .data_i(data_o),
        .last_cmd_o(last_cmd), .cmd_count_o(n_cmd), .rx_busy_o(rx_busy), .drop_o(drop));
    task automatic test_done();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] wd, output logic [31:0] rd);
        int i;
        wb_adr_i <= adr;
        wb_we_i <= we;
        wb_dat_i <= wd;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 50);
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Settle time lets any mode-change status byte go out first
    task automatic mode(input logic [7:0] adr, input logic [31:0] v);
        logic [31:0] r;
        wb(adr, 1'b1, v, r);
        repeat (10) @(posedge clk_i);
    endtask
    task automatic step(input logic [11:0] p, input logic [7:0] exp);
        logic [15:0] c0;
        int i;
        c0 = n_cmd;
        pins_i <= p;
        i = 0;
        while (n_cmd === c0 && i < 40) begin
            @(posedge clk_i);
            i++;
        end
        if (n_cmd === c0) begin
            n_mismatch++;
            test_done();
        end
        repeat (6) @(posedge clk_i);
        check({16'h0000, n_cmd - c0}, 32'h0000_0001);
        check({24'h000000, last_cmd}, {24'h000000, exp});
    endtask
    // Masked or ignored changes must leave the link silent
    task automatic quiet(input logic [11:0] p);
        logic [15:0] c0;
        c0 = n_cmd;
        pins_i <= p;
        repeat (20) @(posedge clk_i);
        check({16'h0000, n_cmd - c0}, 32'h0000_0000);
    endtask
    initial begin
        logic [31:0] r;
        int s0;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        wb(urse_pkg::ADDR_CONTROL, 1'b0, 32'h0, r); check(r, urse_pkg::CONTROL_RESET);
        wb(urse_pkg::ADDR_IRQ_EN, 1'b0, 32'h0, r); check(r, urse_pkg::IRQ_EN_RESET);
        wb(8'h10, 1'b1, 32'hFFFF_FFFF, r);
        wb(8'h10, 1'b0, 32'h0, r); check(r, 32'h0000_0000);
        s0 = n_seen;
        repeat (80) @(posedge clk_i);
        check(n_seen - s0, 32'h0000_000A);
        mode(urse_pkg::ADDR_CONTROL, 32'h05);
        step(12'h880, 8'h01);
        step(12'hC80, 8'h03);
        step(12'h480, 8'h02);
        step(12'h080, 8'h00);
        mode(urse_pkg::ADDR_CONTROL, 32'h04);
        step(12'h280, 8'h00);
        step(12'h180, 8'h01);
        step(12'h080, 8'h02);
        mode(urse_pkg::ADDR_CONTROL, 32'h00);
        step(12'h280, 8'h00);
        mode(urse_pkg::ADDR_CONTROL, 32'h66);
        step(12'h880, 8'h01);
        step(12'h480, 8'h02);
        mode(urse_pkg::ADDR_CONTROL, 32'h65);
        step(12'h880, 8'h01);
        mode(urse_pkg::ADDR_CONTROL, 32'h70);
        step(12'h980, 8'h01);
        step(12'hA80, 8'h00);
        mode(urse_pkg::ADDR_CONTROL, 32'h60);
        step(12'h980, 8'h01);
        quiet(12'h900);
        quiet(12'h980);
        mode(urse_pkg::ADDR_IRQ_EN, 32'h3F);
        step(12'h800, 8'h05);
        step(12'h840, 8'h09);
        step(12'h860, 8'h0D);
        step(12'h800, 8'h05);
        step(12'h880, 8'h01);
        mode(urse_pkg::ADDR_CONTROL, 32'h2E0);
        step(12'h890, 8'h0D);
        step(12'h880, 8'h01);
        mode(urse_pkg::ADDR_CONTROL, 32'h3E0);
        check({24'h000000, last_cmd}, 32'h0000_000D);
        step(12'h890, 8'h01);
        mode(urse_pkg::ADDR_CONTROL, 32'h60);
        step(12'h884, 8'h11);
        check({31'h0, nxt_o & rx_busy}, 32'h0000_0001);
        step(12'h886, 8'h31);
        check({30'h0, nxt_o, drop}, 32'h0000_0001);
        step(12'h880, 8'h01);
        quiet(12'h881);
        quiet(12'h880);
        mode(urse_pkg::ADDR_IRQ_EN, 32'hFF);
        step(12'h881, 8'h21);
        step(12'h880, 8'h01);
        step(12'hAC0, 8'h08);
        mode(urse_pkg::ADDR_CONTROL, 32'h00);
        quiet(12'hAC1);
        step(12'hAC9, 8'h48);
        wb(urse_pkg::ADDR_STATUS, 1'b0, 32'h0, r); check(r, 32'h0000_0048);
        wb(urse_pkg::ADDR_LAST_RXCMD, 1'b0, 32'h0, r); check(r, {16'h0000, n_cmd});
        test_done();
    end
endmodule
bind urse_encoder urse_monitor u_mon (.clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pins_i,
    .dir_o, .nxt_o, .data_o, .data_oe_o, .line_clk_seen_o);
